//--- rtl/mrs_consts.vh
`ifndef MRS_CONSTS_VH
`define MRS_CONSTS_VH

// Coil image width and limits
`define MRS_COIL_W 64
`define MRS_NUM_COILS 17'h00040

// CRC-16 parameters (reflected polynomial, all-ones start)
`define MRS_CRC_INIT 16'hFFFF
`define MRS_CRC_POLY 16'hA001
`define MRS_CRC_RESIDUE 16'h0000

// Function codes
`define MRS_FC_READ_COILS 8'h01
`define MRS_FC_READ_INPUTS 8'h02
`define MRS_FC_READ_HOLDING 8'h03
`define MRS_FC_READ_INPUT_REGS 8'h04
`define MRS_FC_FORCE_COIL 8'h05
`define MRS_FC_PRESET_REG 8'h06
`define MRS_FC_DIAGNOSTIC 8'h08
`define MRS_FC_PRESET_MULTI 8'h10
`define MRS_FC_EXC_FLAG 8'h80

// Exception codes
`define MRS_EXC_ILLEGAL_FUNC 8'h01
`define MRS_EXC_ILLEGAL_ADDR 8'h02
`define MRS_EXC_ILLEGAL_VALUE 8'h03
`define MRS_EXC_DEVICE_ERROR 8'h04
`define MRS_EXC_BUSY 8'h06

// Frame lengths
`define MRS_MIN_FRAME 9'h004
`define MRS_COIL_QUERY_LEN 9'h008
`define MRS_RX_CNT_MAX 9'h1FF
`define MRS_EXC_BODY_LEN 8'h03
`define MRS_READ_HDR_LEN 8'h03

// Counter saturation value
`define MRS_CNT_MAX 16'hFFFF

// One-hot states
`define MRS_ST_RECV 2'h1
`define MRS_ST_SEND 2'h2

`endif

//--- rtl/mrs_crc16_byte.v
// Folds one byte into a running CRC-16, low bit first
module mrs_crc16_byte (
  input wire [15:0] crc_in,
  input wire [7:0] data_in,
  output reg [15:0] crc_out
);

`include "mrs_consts.vh"

  integer i;

  // Eight shift steps of the reflected polynomial
  always @* begin
    crc_out = crc_in ^ {8'h00, data_in};
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_out[0]) begin
        crc_out = (crc_out >> 1) ^ `MRS_CRC_POLY;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end

endmodule

//--- rtl/mrs_slave.v
// Operation
// - Reply goes out only after the query's action, the coil snapshot, is done.
// - A query that cannot be carried out gets an exception reply instead.
// - Supported function codes are 01h 02h 03h 04h 05h 06h 08h 10h only.
// - Unsupported or undefined function code answers exception code 1.
// - Unsupported address in the data field answers exception code 2.
// - Out of range value answers exception code 3.
// - Function disabled or wrong device state answers exception code 4.
// - Busy internal resource answers exception code 6.
// - Exception reply echoes function code with top bit set, code in data.
// - Two byte CRC over address, function and data closes every reply.
// - Query CRC is checked; only matching queries are acted on.
// - Function 01h returns consecutive coil states, one bit each, numbered from zero.
// - Starting coil sits in bit zero of first byte, then upward.
// - Coil reply is address, function, byte count n, n data bytes, CRC.
// - Byte count is bit count over eight rounded up, spare bits zero.
// - Invalid coil gives exception 02h and bumps invalid address counter.
// - Bad count gives 03h, illegal register counter; malformed gives 03h, format counter.
// - Only queries addressed to our station number get any answer.
// - Query with a failing CRC is dropped without any reply.
module mrs_slave (
  input wire CLK_IN,
  input wire RST_N_IN,
  input wire [7:0] OWN_STATION_NUMBER_IN,
  input wire [7:0] RX_BYTE_IN,
  input wire RX_VALID_IN,
  input wire RX_END_IN,
  input wire [63:0] COIL_STATE_IN,
  input wire COIL_READ_EN_IN,
  input wire BUSY_IN,
  input wire TX_READY_IN,
  output reg [7:0] TX_BYTE_OUT,
  output reg TX_VALID_OUT,
  output reg TX_BUSY_OUT,
  output reg OTHER_FUNC_OUT,
  output reg [7:0] QUERY_FUNC_OUT,
  output reg [15:0] INVALID_ADDR_CNT_OUT,
  output reg [15:0] ILLEGAL_REG_CNT_OUT,
  output reg [15:0] BAD_FORMAT_CNT_OUT
);

`include "mrs_consts.vh"

  // One-hot sequencer states
  localparam [1:0] ST_RECV = `MRS_ST_RECV;
  localparam [1:0] ST_SEND = `MRS_ST_SEND;

  reg [1:0] state;
  reg [8:0] rx_cnt;
  reg [15:0] rx_crc;
  reg [7:0] rx_addr;
  reg [7:0] rx_fc;
  reg [15:0] rx_start;
  reg [15:0] rx_qty;
  reg [15:0] tx_crc;
  reg [7:0] tx_pos;
  reg [7:0] tx_len;
  reg [7:0] tx_fc;
  reg tx_exc;
  reg [7:0] tx_exc_code;
  reg [7:0] tx_count;
  reg [63:0] coil_data;

  wire [15:0] rx_crc_next;
  wire [15:0] tx_crc_next;
  reg [7:0] body_byte;
  reg fc_supported;
  reg reply;
  reg exc;
  reg [7:0] exc_code;
  reg bump_addr;
  reg bump_reg;
  reg bump_fmt;
  reg forward;

  wire [16:0] coil_end = {1'b0, rx_start} + {1'b0, rx_qty};
  wire [9:0] qty_round = rx_qty[9:0] + 10'h007;
  wire [7:0] byte_count = {3'h0, qty_round[7:3]};
  wire [63:0] coil_mask = ~({`MRS_COIL_W{1'b1}} << rx_qty[6:0]);
  wire frame_good = (rx_cnt >= `MRS_MIN_FRAME) && (rx_crc == `MRS_CRC_RESIDUE);
  wire frame_end = RX_END_IN && state[0];
  wire tx_load = !TX_VALID_OUT || TX_READY_IN;

  // Running CRC of the received query
  mrs_crc16_byte u_rx_crc (
    .crc_in(rx_crc),
    .data_in(RX_BYTE_IN),
    .crc_out(rx_crc_next)
  );

  // Running CRC of the reply body
  mrs_crc16_byte u_tx_crc (
    .crc_in(tx_crc),
    .data_in(body_byte),
    .crc_out(tx_crc_next)
  );

  // Screen the function code against the supported set
  always @* begin
    case (rx_fc)
      `MRS_FC_READ_COILS, `MRS_FC_READ_INPUTS, `MRS_FC_READ_HOLDING,
      `MRS_FC_READ_INPUT_REGS, `MRS_FC_FORCE_COIL, `MRS_FC_PRESET_REG,
      `MRS_FC_DIAGNOSTIC, `MRS_FC_PRESET_MULTI: begin
        fc_supported = 1'b1;
      end
      default: begin
        fc_supported = 1'b0;
      end
    endcase
  end

  // Decide what a completed query earns
  always @* begin
    reply = 1'b0;
    exc = 1'b0;
    exc_code = `MRS_EXC_ILLEGAL_FUNC;
    bump_addr = 1'b0;
    bump_reg = 1'b0;
    bump_fmt = 1'b0;
    forward = 1'b0;
    if (frame_good && rx_addr == OWN_STATION_NUMBER_IN) begin
      reply = 1'b1;
      if (!fc_supported) begin
        exc = 1'b1;
        exc_code = `MRS_EXC_ILLEGAL_FUNC;
      end else if (rx_fc != `MRS_FC_READ_COILS) begin
        reply = 1'b0;
        forward = 1'b1;
      end else if (BUSY_IN) begin
        exc = 1'b1;
        exc_code = `MRS_EXC_BUSY;
      end else if (!COIL_READ_EN_IN) begin
        exc = 1'b1;
        exc_code = `MRS_EXC_DEVICE_ERROR;
      end else if (rx_cnt != `MRS_COIL_QUERY_LEN) begin
        exc = 1'b1;
        exc_code = `MRS_EXC_ILLEGAL_VALUE;
        bump_fmt = 1'b1;
      end else if ({1'b0, rx_start} >= `MRS_NUM_COILS) begin
        exc = 1'b1;
        exc_code = `MRS_EXC_ILLEGAL_ADDR;
        bump_addr = 1'b1;
      end else if (rx_qty == 16'h0000 || coil_end > `MRS_NUM_COILS) begin
        exc = 1'b1;
        exc_code = `MRS_EXC_ILLEGAL_VALUE;
        bump_reg = 1'b1;
      end
    end
  end

  // Select the body byte at the current reply position
  always @* begin
    case (tx_pos)
      8'h00: begin
        body_byte = rx_addr;
      end
      8'h01: begin
        body_byte = tx_exc ? (tx_fc | `MRS_FC_EXC_FLAG) : tx_fc;
      end
      8'h02: begin
        body_byte = tx_exc ? tx_exc_code : tx_count;
      end
      default: begin
        body_byte = coil_data[7:0];
      end
    endcase
  end

  // Query capture: count bytes, keep header fields, run the CRC
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rx_cnt <= 9'h000;
      rx_crc <= `MRS_CRC_INIT;
      rx_addr <= 8'h00;
      rx_fc <= 8'h00;
      rx_start <= 16'h0000;
      rx_qty <= 16'h0000;
    end else if (!state[0] || frame_end) begin
      rx_cnt <= 9'h000;
      rx_crc <= `MRS_CRC_INIT;
    end else if (RX_VALID_IN) begin
      rx_crc <= rx_crc_next;
      if (rx_cnt != `MRS_RX_CNT_MAX) begin
        rx_cnt <= rx_cnt + 9'h001;
      end
      case (rx_cnt)
        9'h000: begin
          rx_addr <= RX_BYTE_IN;
        end
        9'h001: begin
          rx_fc <= RX_BYTE_IN;
        end
        9'h002: begin
          rx_start[15:8] <= RX_BYTE_IN;
        end
        9'h003: begin
          rx_start[7:0] <= RX_BYTE_IN;
        end
        9'h004: begin
          rx_qty[15:8] <= RX_BYTE_IN;
        end
        9'h005: begin
          rx_qty[7:0] <= RX_BYTE_IN;
        end
        default: begin
          rx_fc <= rx_fc;
        end
      endcase
    end
  end

  // Main sequencer: take decision, snapshot coils, stream the reply
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= ST_RECV;
      tx_pos <= 8'h00;
      tx_len <= 8'h00;
      tx_fc <= 8'h00;
      tx_exc <= 1'b0;
      tx_exc_code <= 8'h00;
      tx_count <= 8'h00;
      tx_crc <= `MRS_CRC_INIT;
      coil_data <= 64'h0000000000000000;
      TX_BYTE_OUT <= 8'h00;
      TX_VALID_OUT <= 1'b0;
      TX_BUSY_OUT <= 1'b0;
    end else begin
      case (state)
        ST_RECV: begin
          if (frame_end && reply) begin
            state <= ST_SEND;
            TX_BUSY_OUT <= 1'b1;
            tx_pos <= 8'h00;
            tx_crc <= `MRS_CRC_INIT;
            tx_fc <= rx_fc;
            tx_exc <= exc;
            tx_exc_code <= exc_code;
            tx_count <= byte_count;
            tx_len <= exc ? `MRS_EXC_BODY_LEN : (`MRS_READ_HDR_LEN + byte_count);
            // Coil snapshot is the query's action, taken before any byte leaves
            coil_data <= (COIL_STATE_IN >> rx_start[5:0]) & coil_mask;
          end
        end
        ST_SEND: begin
          if (tx_load) begin
            if (tx_pos < tx_len) begin
              TX_BYTE_OUT <= body_byte;
              TX_VALID_OUT <= 1'b1;
              tx_crc <= tx_crc_next;
              tx_pos <= tx_pos + 8'h01;
              if (tx_pos >= `MRS_READ_HDR_LEN) begin
                coil_data <= coil_data >> 8;
              end
            end else if (tx_pos == tx_len) begin
              TX_BYTE_OUT <= tx_crc[7:0];
              TX_VALID_OUT <= 1'b1;
              tx_pos <= tx_pos + 8'h01;
            end else if (tx_pos == tx_len + 8'h01) begin
              TX_BYTE_OUT <= tx_crc[15:8];
              TX_VALID_OUT <= 1'b1;
              tx_pos <= tx_pos + 8'h01;
            end else begin
              TX_VALID_OUT <= 1'b0;
              TX_BUSY_OUT <= 1'b0;
              state <= ST_RECV;
            end
          end
        end
        default: begin
          state <= ST_RECV;
          TX_VALID_OUT <= 1'b0;
          TX_BUSY_OUT <= 1'b0;
        end
      endcase
    end
  end

  // Error counters and hand-off of other supported functions
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      INVALID_ADDR_CNT_OUT <= 16'h0000;
      ILLEGAL_REG_CNT_OUT <= 16'h0000;
      BAD_FORMAT_CNT_OUT <= 16'h0000;
      OTHER_FUNC_OUT <= 1'b0;
      QUERY_FUNC_OUT <= 8'h00;
    end else begin
      OTHER_FUNC_OUT <= frame_end && forward;
      if (frame_end && (reply || forward)) begin
        QUERY_FUNC_OUT <= rx_fc;
      end
      if (frame_end && bump_addr && INVALID_ADDR_CNT_OUT != `MRS_CNT_MAX) begin
        INVALID_ADDR_CNT_OUT <= INVALID_ADDR_CNT_OUT + 16'h0001;
      end
      if (frame_end && bump_reg && ILLEGAL_REG_CNT_OUT != `MRS_CNT_MAX) begin
        ILLEGAL_REG_CNT_OUT <= ILLEGAL_REG_CNT_OUT + 16'h0001;
      end
      if (frame_end && bump_fmt && BAD_FORMAT_CNT_OUT != `MRS_CNT_MAX) begin
        BAD_FORMAT_CNT_OUT <= BAD_FORMAT_CNT_OUT + 16'h0001;
      end
    end
  end

endmodule

//--- sim/mrs_chk.sv
// Watches the slave's ports for reply timing and counter behaviour
module mrs_chk (
  input wire CLK_IN,
  input wire RST_N_IN,
  input wire [7:0] OWN_STATION_NUMBER_IN,
  input wire RX_END_IN,
  input wire TX_READY_IN,
  input wire [7:0] TX_BYTE_OUT,
  input wire TX_VALID_OUT,
  input wire TX_BUSY_OUT,
  input wire OTHER_FUNC_OUT,
  input wire [15:0] INVALID_ADDR_CNT_OUT,
  input wire [15:0] ILLEGAL_REG_CNT_OUT,
  input wire [15:0] BAD_FORMAT_CNT_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // Reply framing
  property p_start;
    $rose(TX_BUSY_OUT) |-> $past(RX_END_IN);
  endproperty
  a_start: assert property (p_start) else $error("reply began without frame end");
  property p_first;
    $rose(TX_BUSY_OUT) |=> TX_VALID_OUT && TX_BYTE_OUT == OWN_STATION_NUMBER_IN;
  endproperty
  a_first: assert property (p_first) else $error("first reply byte wrong");
  property p_hold;
    TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_BYTE_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte moved while stalled");
  property p_end;
    $fell(TX_BUSY_OUT) |-> $past(TX_VALID_OUT && TX_READY_IN);
  endproperty
  a_end: assert property (p_end) else $error("reply ended without last byte");
  // Supported codes handled elsewhere
  property p_other;
    OTHER_FUNC_OUT |=> (!OTHER_FUNC_OUT && !TX_BUSY_OUT) [*3];
  endproperty
  a_other: assert property (p_other) else $error("other code pulse or reply");
  // Counters step by one and saturate
  property p_inv;
    INVALID_ADDR_CNT_OUT != $past(INVALID_ADDR_CNT_OUT) |->
      {1'b0, INVALID_ADDR_CNT_OUT} == $past(INVALID_ADDR_CNT_OUT) + 17'h00001;
  endproperty
  a_inv: assert property (p_inv) else $error("invalid address count step");
  property p_ill;
    ILLEGAL_REG_CNT_OUT != $past(ILLEGAL_REG_CNT_OUT) |->
      {1'b0, ILLEGAL_REG_CNT_OUT} == $past(ILLEGAL_REG_CNT_OUT) + 17'h00001;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal register count step");
  property p_fmt;
    BAD_FORMAT_CNT_OUT != $past(BAD_FORMAT_CNT_OUT) |->
      {1'b0, BAD_FORMAT_CNT_OUT} == $past(BAD_FORMAT_CNT_OUT) + 17'h00001;
  endproperty
  a_fmt: assert property (p_fmt) else $error("bad format count step");
endmodule

bind mrs_slave mrs_chk u_mrs_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .OWN_STATION_NUMBER_IN(OWN_STATION_NUMBER_IN), .RX_END_IN(RX_END_IN),
  .TX_READY_IN(TX_READY_IN), .TX_BYTE_OUT(TX_BYTE_OUT), .TX_VALID_OUT(TX_VALID_OUT),
  .TX_BUSY_OUT(TX_BUSY_OUT), .OTHER_FUNC_OUT(OTHER_FUNC_OUT),
  .INVALID_ADDR_CNT_OUT(INVALID_ADDR_CNT_OUT), .ILLEGAL_REG_CNT_OUT(ILLEGAL_REG_CNT_OUT),
  .BAD_FORMAT_CNT_OUT(BAD_FORMAT_CNT_OUT));

//--- sim/mrs_master.sv
// Serial master: sends queries, gathers replies
module mrs_master (
  input wire logic clk_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  input wire logic tx_busy_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic rx_end_out,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rsp[$];
  logic slow;
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_end_out = 1'b0;
    tx_ready_out = 1'b1;
    slow = 1'b0;
  end
  // Take accepted bytes; stall every other cycle when slow
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) rsp.push_back(tx_byte_in);
    tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
  end
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[k]) begin
      c = c ^ {8'h00, q[k]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  // Frame usable only with zero residue
  function automatic bit good();
    return rsp.size() > 2 && crc(rsp) == 16'h0000;
  endfunction
  // Query bytes, CRC low first, then frame end; waits out the reply
  task automatic send(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    int j;
    c = crc(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    rsp.delete();
    for (j = 0; j < q.size(); j++) begin
      @(posedge clk_in);
      rx_byte_out <= q[j];
      rx_valid_out <= 1'b1;
    end
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~q[q.size()-1]; // Released line shows no stale byte
    rx_end_out <= 1'b1;
    @(posedge clk_in);
    rx_end_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    for (j = 0; j < 400 && tx_busy_in; j++) @(posedge clk_in);
    @(posedge clk_in);
  endtask
endmodule

//--- sim/mrs_slave_tb_top.sv
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module mrs_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] own = 8'h11;
  logic [63:0] coils = 64'hA5C30F817E24D91B;
  logic en = 1'b1;
  logic busy = 1'b0;
  wire [7:0] rx_byte, tx_byte, qfc;
  wire rx_valid, rx_end, tx_ready, tx_valid, tx_busy, other;
  wire [15:0] inv, ill, fmt;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int others = 0;
  always #5 clk = ~clk;
  mrs_master u_mrs_master (.clk_in(clk), .tx_byte_in(tx_byte), .tx_valid_in(tx_valid),
    .tx_busy_in(tx_busy), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
    .rx_end_out(rx_end), .tx_ready_out(tx_ready));
  mrs_slave u_mrs_slave (.CLK_IN(clk), .RST_N_IN(rst_n), .OWN_STATION_NUMBER_IN(own),
    .RX_BYTE_IN(rx_byte), .RX_VALID_IN(rx_valid), .RX_END_IN(rx_end), .COIL_STATE_IN(coils),
    .COIL_READ_EN_IN(en), .BUSY_IN(busy), .TX_READY_IN(tx_ready), .TX_BYTE_OUT(tx_byte),
    .TX_VALID_OUT(tx_valid), .TX_BUSY_OUT(tx_busy), .OTHER_FUNC_OUT(other),
    .QUERY_FUNC_OUT(qfc), .INVALID_ADDR_CNT_OUT(inv), .ILLEGAL_REG_CNT_OUT(ill),
    .BAD_FORMAT_CNT_OUT(fmt));
  // Pulse counting and hang limit
  always @(posedge clk) begin
    if (other === 1'b1) others++;
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic set_in(input logic b, input logic e);
    @(posedge clk);
    busy <= b;
    en <= e;
  endtask
  task automatic t_read(input logic [15:0] st, input logic [15:0] n, input bit sl);
    logic [7:0] nb, d;
    int j, k;
    nb = 8'((n + 16'h0007) >> 3);
    u_mrs_master.slow = sl;
    u_mrs_master.send('{own, 8'h01, st[15:8], st[7:0], n[15:8], n[7:0]}, 1'b0);
    u_mrs_master.slow = 1'b0;
    `CHK("len", 32'(nb) + 5, u_mrs_master.rsp.size())
    `CHK("crc", 1'b1, u_mrs_master.good())
    `CHK("fc", 8'h01, u_mrs_master.rsp[1])
    `CHK("n", nb, u_mrs_master.rsp[2])
    for (j = 0; j < nb; j++) begin
      for (k = 0; k < 8; k++) d[k] = (8*j+k < n) ? coils[st+8*j+k] : 1'b0;
      `CHK("data", d, u_mrs_master.rsp[3+j])
    end
  endtask
  task automatic t_exc(input logic [7:0] fc, input logic [7:0] q[$], input logic [7:0] code);
    q.push_front(fc);
    q.push_front(own);
    u_mrs_master.send(q, 1'b0);
    `CHK("exc len", 5, u_mrs_master.rsp.size())
    `CHK("exc fc", fc | 8'h80, u_mrs_master.rsp[1])
    `CHK("exc code", code, u_mrs_master.rsp[2])
    `CHK("exc crc", 1'b1, u_mrs_master.good())
  endtask
  task automatic t_silent(input logic [7:0] adr, input bit bad);
    u_mrs_master.send('{adr, 8'h01, 8'h00, 8'h40, 8'h00, 8'h01}, bad);
    `CHK("silent", 0, u_mrs_master.rsp.size())
    `CHK("inv kept", 16'h0001, inv)
  endtask
  task automatic t_other();
    logic [7:0] ol[7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h10};
    int o;
    foreach (ol[i]) begin
      o = others;
      u_mrs_master.send('{own, ol[i], 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
      `CHK("no reply", 0, u_mrs_master.rsp.size())
      `CHK("pulses", o + 1, others)
      `CHK("qfc", ol[i], qfc)
    end
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_read(16'h0000, 16'h000A, 1'b0);
    t_read(16'h0003, 16'h0011, 1'b1);
    t_read(16'h0038, 16'h0008, 1'b0);
    t_read(16'h0000, 16'h0040, 1'b1);
    t_exc(8'h07, '{8'h00}, 8'h01);
    set_in(1'b1, 1'b1);
    t_exc(8'h01, '{8'h00, 8'h00, 8'h00, 8'h01}, 8'h06);
    set_in(1'b0, 1'b0);
    t_exc(8'h01, '{8'h00, 8'h00, 8'h00, 8'h01}, 8'h04);
    set_in(1'b0, 1'b1);
    t_exc(8'h01, '{8'h00, 8'h40, 8'h00, 8'h01}, 8'h02);
    `CHK("inv", 16'h0001, inv)
    t_exc(8'h01, '{8'h00, 8'h00, 8'h00, 8'h00}, 8'h03);
    t_exc(8'h01, '{8'h00, 8'h3C, 8'h00, 8'h05}, 8'h03);
    `CHK("ill", 16'h0002, ill)
    t_exc(8'h01, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00}, 8'h03);
    `CHK("fmt", 16'h0001, fmt)
    t_silent(8'h12, 1'b0);
    t_silent(own, 1'b1);
    t_other();
    tally_and_finish();
  end
endmodule
